// *** design/dsp_mac_block.sv ***
// Decided for this implementation: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module dsp_mac_block
    import dsp_mac_pkg::*;
(
    input  wire logic            hclk,
    input  wire logic            hresetn,
    input  wire logic            hsel,
    input  wire logic [31:0]     haddr,
    input  wire logic [1:0]      htrans,
    input  wire logic            hwrite,
    input  wire logic [2:0]      hsize,
    input  wire logic [31:0]     hwdata,
    input  wire logic            hready,
    output logic                 hreadyout,
    output logic                 hresp,
    output logic [31:0]          hrdata,
    input  wire operand_s        opnd,
    input  wire ctrl_s           ctrl,
    input  wire chain_s          chain_in,
    output chain_s               chain_out,
    output logic [RESW-1:0]      result
);

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic                       wr_pend_r;
    logic [31:0]                wr_addr_r;
    logic [31:0]                hrdata_r;
    cfg_s                       cfg_r;
    logic [1:0]                 stat_r;
    logic [1:0]                 w1c;
    logic [1:0]                 sat_ev;
    logic [1:0]                 fix;
    logic                       whole;
    half_cfg_s                  eff [2];
    logic [3:0]                 ena;
    logic [3:0]                 clr;
    logic [1:0]                 rnd;
    logic [1:0]                 sat;
    logic [1:0]                 addsub;
    logic [UNITS-1:0][OPW-1:0]  a_r;
    logic [UNITS-1:0][OPW-1:0]  b_r;
    logic [UNITS-1:0][OPW-1:0]  a_prev;
    logic [UNITS-1:0][OPW-1:0]  b_prev;
    logic signed [37:0]         p18 [UNITS];
    logic signed [37:0]         q [UNITS];
    logic [UNITS-1:0]           sat_hit;
    logic signed [19:0]         p9lo [UNITS];
    logic signed [19:0]         p9hi [UNITS];
    logic signed [38:0]         pair18 [2];
    logic signed [20:0]         pair9 [2][2];
    logic signed [39:0]         sum18;
    logic signed [21:0]         sum9 [2];
    logic signed [73:0]         p36;
    logic [ACCW-1:0]            acc_r [2];
    logic [ACCW-1:0]            acc_nxt [2];
    logic [RESW-1:0]            res_nxt;
    logic [RESW-1:0]            res_r;

    // Control bundle from the fabric
    assign ena    = ctrl.unit_clock_enable;
    assign clr    = ctrl.unit_async_clear;
    assign rnd    = {ctrl.product_pair_hi_round, ctrl.product_pair_lo_round};
    assign sat    = {ctrl.product_pair_hi_saturate, ctrl.product_pair_lo_saturate};
    assign addsub = {ctrl.sum_add_or_subtract_hi, ctrl.sum_add_or_subtract_lo};

    // ----------------------------------------------------------------
    // Bus slave: zero wait states, always OKAY
    // ----------------------------------------------------------------
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= '0;
        end
        else if (hready)
        begin
            wr_pend_r <= hsel && htrans[1] && hwrite && (hsize == WORD_SIZE);
            wr_addr_r <= haddr;
        end
    end

    // Read data is captured in the address phase, so a read that directly
    // follows a write to the same register returns the old value
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_r <= '0;
        else if (hready && hsel && htrans[1] && !hwrite)
        begin
            if (haddr == CFG_ADDR)
                hrdata_r <= {16'h0000, cfg_r};
            else if (haddr == STAT_ADDR)
                hrdata_r <= {28'h0000000, fix, stat_r};
            else
                hrdata_r <= '0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cfg_r <= cfg_s'(CFG_RESET);
        else if (wr_pend_r && wr_addr_r == CFG_ADDR)
            cfg_r <= cfg_s'(hwdata[15:0]);
    end

    assign w1c = (wr_pend_r && wr_addr_r == STAT_ADDR) ? hwdata[1:0] : 2'h0;

    // Set wins over a clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            stat_r <= STAT_RESET;
        else
            stat_r <= (stat_r & ~w1c) | sat_ev;
    end

    // ----------------------------------------------------------------
    // Mode decode
    // ----------------------------------------------------------------
    always_comb
    begin
        eff[0] = cfg_r.block_config_select_lo;
        eff[1] = cfg_r.block_config_select_hi;
        for (int h = 0; h < 2; h++)
        begin
            if (eff[h].size != SIZE_9 && eff[h].size != SIZE_36)
                eff[h].size = SIZE_18;
            if (eff[h].size == SIZE_36 || (eff[h].mode == MODE_ACCUM && eff[h].size == SIZE_9))
                eff[h].mode = MODE_MULT;
        end
        // A 36x36 product or a four-product sum selected in the low half takes the whole block; in the high half it falls back to an 18x18 product
        whole = eff[0].size == SIZE_36 || eff[0].mode == MODE_ADD4;
        if (whole)
            eff[1] = eff[0];
        else if (eff[1].size == SIZE_36 || eff[1].mode == MODE_ADD4)
            eff[1] = '{SIZE_18, MODE_MULT};
        fix[0] = eff[0] != cfg_r.block_config_select_lo;
        fix[1] = !whole && (eff[1] != cfg_r.block_config_select_hi);
    end

    // ----------------------------------------------------------------
    // Operand registers and shift chain
    // ----------------------------------------------------------------
    assign a_prev = {a_r[UNITS-2:0], chain_in.a};
    assign b_prev = {b_r[UNITS-2:0], chain_in.b};

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            a_r <= '0;
            b_r <= '0;
        end
        else
        begin
            for (int i = 0; i < UNITS; i++)
            begin
                if (clr[i])
                begin
                    a_r[i] <= '0;
                    b_r[i] <= '0;
                end
                else if (ena[i])
                begin
                    a_r[i] <= cfg_r.shift_a[i] ? a_prev[i] : opnd.a[i];
                    b_r[i] <= cfg_r.shift_b[i] ? b_prev[i] : opnd.b[i];
                end
            end
        end
    end

    // Same flops feed the next block and the general routing
    assign chain_out = '{b: b_r[UNITS-1], a: a_r[UNITS-1]};

    // ----------------------------------------------------------------
    // Multipliers
    // ----------------------------------------------------------------
    function automatic logic signed [18:0] ext18(input logic [17:0] v, input logic s);
        return $signed({s & v[17], v});
    endfunction

    function automatic logic signed [9:0] ext9(input logic [8:0] v, input logic s);
        return $signed({s & v[8], v});
    endfunction

    // Rounding clears the fraction below Q1.15; clamp when the top bits
    // no longer agree with the sign
    function automatic logic [38:0] q115(input logic signed [37:0] p,
                                         input logic rd, input logic st);
        logic signed [37:0] v;
        logic               ovf;
        v = rd ? p + RND_HALF : p;
        if (rd)
            v[FRAC-1:0] = '0;
        ovf = v != 38'($signed(v[SAT_MSB:0]));
        if (st && ovf)
            v = v[37] ? Q_MIN : Q_MAX;
        return {st && ovf, v};
    endfunction

    always_comb
    begin
        for (int i = 0; i < UNITS; i++)
        begin
            p18[i]  = ext18(a_r[i], ctrl.sign_a) * ext18(b_r[i], ctrl.sign_b);
            {sat_hit[i], q[i]} = q115(p18[i], rnd[i/2], sat[i/2]);
            p9lo[i] = ext9(a_r[i][SUBW-1:0], ctrl.sign_a) * ext9(b_r[i][SUBW-1:0], ctrl.sign_b);
            p9hi[i] = ext9(a_r[i][OPW-1:SUBW], ctrl.sign_a) * ext9(b_r[i][OPW-1:SUBW], ctrl.sign_b);
        end
        for (int h = 0; h < 2; h++)
        begin
            pair18[h]   = addsub[h] ? q[2*h] + q[2*h+1] : q[2*h] - q[2*h+1];
            pair9[h][0] = addsub[h] ? p9lo[2*h] + p9lo[2*h+1] : p9lo[2*h] - p9lo[2*h+1];
            pair9[h][1] = addsub[h] ? p9hi[2*h] + p9hi[2*h+1] : p9hi[2*h] - p9hi[2*h+1];
        end
        sum18   = pair18[0] + pair18[1];
        sum9[0] = pair9[0][0] + pair9[1][0];
        sum9[1] = pair9[0][1] + pair9[1][1];
        p36 = $signed({ctrl.sign_a & a_r[1][17], a_r[1], a_r[0]})
            * $signed({ctrl.sign_b & b_r[1][17], b_r[1], b_r[0]});
    end

    // ----------------------------------------------------------------
    // Accumulators
    // ----------------------------------------------------------------
    always_comb
    begin
        for (int h = 0; h < 2; h++)
        begin
            if (ctrl.accum_load[h])
                acc_nxt[h] = ACCW'(q[2*h]);
            else if (addsub[h])
                acc_nxt[h] = acc_r[h] + ACCW'(q[2*h]);
            else
                acc_nxt[h] = acc_r[h] - ACCW'(q[2*h]);
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            acc_r[0] <= '0;
            acc_r[1] <= '0;
        end
        else
        begin
            for (int h = 0; h < 2; h++)
            begin
                if (clr[2*h])
                    acc_r[h] <= '0;
                else if (ena[2*h] && eff[h].mode == MODE_ACCUM)
                    acc_r[h] <= acc_nxt[h];
            end
        end
    end

    // ----------------------------------------------------------------
    // Result selection and output registers
    // ----------------------------------------------------------------
    always_comb
    begin
        res_nxt = '0;
        if (whole)
        begin
            // No adder stage after the wide product; the fabric adds it
            if (eff[0].size == SIZE_36)
                res_nxt[RESW/2-1:0] = p36[RESW/2-1:0];
            else if (eff[0].size == SIZE_18)
                res_nxt[3*OPW-1:0] = (3*OPW)'(sum18);
            else
                res_nxt[RESW/2-1:0] = {(2*OPW)'(sum9[1]), (2*OPW)'(sum9[0])};
        end
        else
        begin
            for (int h = 0; h < 2; h++)
            begin
                case (eff[h].mode)
                MODE_MULT:
                    if (eff[h].size == SIZE_18)
                        res_nxt[h*RESW/2 +: RESW/2] = {q[2*h+1][35:0], q[2*h][35:0]};
                    else
                        res_nxt[h*RESW/2 +: RESW/2] = {p9hi[2*h+1][17:0], p9lo[2*h+1][17:0],
                                                       p9hi[2*h][17:0], p9lo[2*h][17:0]};
                MODE_ACCUM:
                    res_nxt[h*RESW/2 +: 3*OPW] = (3*OPW)'($signed(acc_r[h]));
                MODE_ADD2:
                    if (eff[h].size == SIZE_18)
                        res_nxt[h*RESW/2 +: 3*OPW] = (3*OPW)'(pair18[h]);
                    else
                        res_nxt[h*RESW/2 +: RESW/2] = {(2*OPW)'(pair9[h][1]),
                                                       (2*OPW)'(pair9[h][0])};
                default:
                    res_nxt[h*RESW/2 +: RESW/2] = '0;
                endcase
            end
        end
    end

    // Each unit owns two result words
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            res_r <= '0;
        else
        begin
            for (int i = 0; i < UNITS; i++)
            begin
                if (clr[i])
                    res_r[i*2*OPW +: 2*OPW] <= '0;
                else if (ena[i])
                    res_r[i*2*OPW +: 2*OPW] <= res_nxt[i*2*OPW +: 2*OPW];
            end
        end
    end

    assign result = res_r;

    always_comb
    begin
        for (int h = 0; h < 2; h++)
            sat_ev[h] = eff[h].size == SIZE_18
                      && ((sat_hit[2*h] && ena[2*h]) || (sat_hit[2*h+1] && ena[2*h+1]));
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_accum_sync_load: assert property (
        eff[0].mode == MODE_ACCUM && ena[0] && !clr[0] && ctrl.accum_load[0]
        |=> acc_r[0] == ACCW'($past(q[0])))
        else $error("accumulator load did not take the product");

    a_accum_add_sub: assert property (
        eff[0].mode == MODE_ACCUM && ena[0] && !clr[0] && !ctrl.accum_load[0]
        |=> acc_r[0] == ($past(addsub[0]) ? $past(acc_r[0]) + ACCW'($past(q[0]))
                                          : $past(acc_r[0]) - ACCW'($past(q[0]))))
        else $error("accumulator step wrong");

    a_no_accum_wide: assert property (
        cfg_r.block_config_select_lo.size == SIZE_36 && !clr[0]
        |=> acc_r[0] == $past(acc_r[0]))
        else $error("accumulator moved at 36x36 size");

    a_plain_mult18: assert property (
        !whole && eff[0] == half_cfg_s'{SIZE_18, MODE_MULT} && ena[0] && !clr[0]
        && !rnd[0] && !sat[0]
        |=> res_r[2*OPW-1:0] == (2*OPW)'($past(p18[0])))
        else $error("18x18 product wrong");

    a_plain_mult9: assert property (
        !whole && eff[0] == half_cfg_s'{SIZE_9, MODE_MULT} && ena[0] && !clr[0]
        |=> res_r[OPW-1:0] == $past(p9lo[0][17:0]))
        else $error("9x9 product wrong");

    a_unsigned_mult: assert property (
        !whole && eff[0] == half_cfg_s'{SIZE_18, MODE_MULT} && ena[0] && !clr[0]
        && !rnd[0] && !sat[0] && !ctrl.sign_a && !ctrl.sign_b
        |=> res_r[2*OPW-1:0] == (2*OPW)'($past(a_r[0])) * (2*OPW)'($past(b_r[0])))
        else $error("unsigned product wrong");

    a_q115_clamp: assert property (
        !whole && eff[0] == half_cfg_s'{SIZE_18, MODE_MULT} && ena[0] && !clr[0] && sat[0]
        |=> $signed(res_r[2*OPW-1:0]) <= $signed((2*OPW)'(Q_MAX))
            && $signed(res_r[2*OPW-1:0]) >= $signed((2*OPW)'(Q_MIN)))
        else $error("saturated result out of range");

    a_shift_step: assert property (
        cfg_r.shift_a[1] && ena[1] && !clr[1]
        |=> a_r[1] == $past(a_r[0]))
        else $error("shift chain step lost");

    a_chain_through: assert property (
        (cfg_r.shift_a == 4'hF && ena == 4'hF && clr == 4'h0)[*4]
        |=> chain_out.a == $past(chain_in.a, 4))
        else $error("chain did not reach the output");

    c_accum_run: cover property (
        eff[0].mode == MODE_ACCUM && ena[0] && ctrl.accum_load[0]
        ##1 ena[0] && !ctrl.accum_load[0]);
    c_mult36: cover property (eff[0].size == SIZE_36 && ena[0]);
    c_add4_9: cover property (eff[0] == half_cfg_s'{SIZE_9, MODE_ADD4} && ena[0]);
    c_sat_event: cover property (sat_ev[0]);

endmodule

`default_nettype wire

// *** design/dsp_mac_pkg.sv ***
`default_nettype none

package dsp_mac_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int OPW     = 18;
    localparam int SUBW    = 9;
    localparam int ACCW    = 52;
    localparam int UNITS   = 4;
    localparam int RESW    = 144;
    localparam int FRAC    = 15;
    localparam int SAT_MSB = 30;

    // ----------------------------------------------------------------
    // Register map and reset values
    // ----------------------------------------------------------------
    localparam logic [31:0] CFG_ADDR   = 32'h0000_0000;
    localparam logic [31:0] STAT_ADDR  = 32'h0000_0004;
    localparam logic [2:0]  WORD_SIZE  = 3'h2;
    localparam logic [15:0] CFG_RESET  = 16'h0000;
    localparam logic [1:0]  STAT_RESET = 2'h0;

    // Q1.15 rounding half step and clamp limits on the Q2.30 product
    localparam logic signed [37:0] RND_HALF = 38'sh00_0000_4000;
    localparam logic signed [37:0] Q_MAX    = 38'sh00_3FFF_8000;
    localparam logic signed [37:0] Q_MIN    = 38'sh3F_C000_0000;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_MULT  = 2'b00,
        MODE_ACCUM = 2'b01,
        MODE_ADD2  = 2'b10,
        MODE_ADD4  = 2'b11
    } mode_e;

    typedef enum logic [1:0] {
        SIZE_9  = 2'b00,
        SIZE_18 = 2'b01,
        SIZE_36 = 2'b10
    } size_e;

    typedef struct packed {
        size_e size;
        mode_e mode;
    } half_cfg_s;

    typedef struct packed {
        logic [3:0] shift_b;
        logic [3:0] shift_a;
        half_cfg_s  block_config_select_hi;
        half_cfg_s  block_config_select_lo;
    } cfg_s;

    typedef struct packed {
        logic [UNITS-1:0][OPW-1:0] b;
        logic [UNITS-1:0][OPW-1:0] a;
    } operand_s;

    typedef struct packed {
        logic [OPW-1:0] b;
        logic [OPW-1:0] a;
    } chain_s;

    typedef struct packed {
        logic       sign_a;
        logic       sign_b;
        logic       sum_add_or_subtract_hi;
        logic       sum_add_or_subtract_lo;
        logic       product_pair_hi_round;
        logic       product_pair_lo_round;
        logic       product_pair_hi_saturate;
        logic       product_pair_lo_saturate;
        logic [1:0] accum_load;
        logic [3:0] unit_clock_enable;
        logic [3:0] unit_async_clear;
    } ctrl_s;

endpackage

`default_nettype wire

// *** testbench/fabric_rows.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Fabric rows feeding the block
// ----------------------------------------------------------------
module fabric_rows
    import dsp_mac_pkg::*;
(
    input  wire logic     hclk,
    input  wire logic     hresetn,
    input  wire operand_s opnd_set,
    input  wire ctrl_s    ctrl_set,
    input  wire chain_s   chain_set,
    output operand_s      opnd,
    output ctrl_s         ctrl,
    output chain_s        chain_in
);
    // All fields launch off one edge, so a bundle never arrives skewed
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            opnd     <= '0;
            ctrl     <= '0;
            chain_in <= '0;
        end
        else
        begin
            opnd     <= opnd_set;
            ctrl     <= ctrl_set;
            chain_in <= chain_set;
        end
    end
    // Any sum of a 36x36 product belongs here; the bench forms none
endmodule

`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, x) begin samples_checked++; if ((g) !== (x)) begin err_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (x)); end end

module tb_top
    import dsp_mac_pkg::*;
;
    logic              hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0]       haddr, hwdata, hrdata, q;
    logic [1:0]        htrans;
    logic [2:0]        hsize;
    operand_s          opnd, opnd_set;
    ctrl_s             ctrl, ctrl_set;
    chain_s            chain_in, chain_set, chain_out;
    logic [RESW-1:0]   result;
    logic signed [75:0] e, p;
    logic              hs;
    int                err_count, samples_checked, seed;

    dsp_mac_block i_dsp_mac_block (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .opnd(opnd), .ctrl(ctrl), .chain_in(chain_in), .chain_out(chain_out),
        .result(result));
    fabric_rows i_fabric_rows (.hclk(hclk), .hresetn(hresetn), .opnd_set(opnd_set),
        .ctrl_set(ctrl_set), .chain_set(chain_set), .opnd(opnd), .ctrl(ctrl),
        .chain_in(chain_in));

    initial
    begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    // ----------------------------------------------------------------
    // Expectation helpers
    // ----------------------------------------------------------------
    function automatic logic signed [75:0] mul(input logic [35:0] a, b, input int w,
                                               input logic sa, sb);
        logic signed [75:0] x;
        logic signed [75:0] y;
        x = a & ((76'd1 << w) - 1);
        y = b & ((76'd1 << w) - 1);
        if (sa && a[w-1])
            x = x - (76'sd1 <<< w);
        if (sb && b[w-1])
            y = y - (76'sd1 <<< w);
        return x * y;
    endfunction

    function automatic logic [35:0] rs(input logic signed [75:0] v, input logic r, s);
        if (r)
            v = (v + RND_HALF) & ~76'h7FFF;
        if (s && v > 76'sh3FFF_FFFF)
            v = Q_MAX;
        if (s && v < -76'sh4000_0000)
            v = Q_MIN;
        return v[35:0];
    endfunction

    // ----------------------------------------------------------------
    // Bus and stimulus tasks
    // ----------------------------------------------------------------
    task automatic final_report;
        $display("checks=%0d errors=%0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Bounded: a slave that never answers ends the run instead of hanging it
    task automatic wait_ready;
        for (int n = 0; n < 20; n++)
        begin
            @(posedge hclk);
            if (hreadyout === 1'b1)
                return;
        end
        err_count++;
        final_report();
    endtask

    task automatic bus(input logic w, input logic [31:0] a, d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize  <= WORD_SIZE;
        wait_ready();
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= d;
        wait_ready();
        q = hrdata;
    endtask

    task automatic rnd_ops;
        @(posedge hclk);
        for (int i = 0; i < 4; i++)
        begin
            opnd_set.a[i] <= 18'($random(seed));
            opnd_set.b[i] <= 18'($random(seed));
        end
        ctrl_set.sign_a <= 1'($random(seed));
        ctrl_set.sign_b <= 1'($random(seed));
    endtask

    task automatic run(input logic [3:0] en);
        @(posedge hclk);
        ctrl_set.unit_clock_enable <= en;
        repeat (6) @(posedge hclk);
        #1;
    endtask

    function automatic logic signed [75:0] pr(input int i);
        return mul(opnd_set.a[i], opnd_set.b[i], 18, ctrl_set.sign_a, ctrl_set.sign_b);
    endfunction

    task automatic chk_units(input int w);
        logic r;
        logic s;
        logic sa;
        logic sb;
        sa = ctrl_set.sign_a;
        sb = ctrl_set.sign_b;
        for (int i = 0; i < 4; i++)
        begin
            r = (i < 2) ? ctrl_set.product_pair_lo_round : ctrl_set.product_pair_hi_round;
            s = (i < 2) ? ctrl_set.product_pair_lo_saturate : ctrl_set.product_pair_hi_saturate;
            if (w == 9)
            begin
                e = mul(opnd_set.a[i][8:0], opnd_set.b[i][8:0], 9, sa, sb);
                `CHK(result[36*i+:18], e[17:0])
                e = mul(opnd_set.a[i][17:9], opnd_set.b[i][17:9], 9, sa, sb);
                `CHK(result[36*i+18+:18], e[17:0])
            end
            else
                `CHK(result[36*i+:36], rs(pr(i), r, s))
        end
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        seed = 45;
        err_count = 0;
        samples_checked = 0;
        {hresetn, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
        opnd_set = '0;
        ctrl_set = '0;
        chain_set = '0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, CFG_ADDR, 32'h0);
        `CHK(q[15:0], CFG_RESET)
        bus(1'b0, STAT_ADDR, 32'h0);
        `CHK(q[1:0], STAT_RESET)
        bus(1'b0, 32'h0000_0008, 32'h0);
        `CHK(q, 32'h0)
        for (int k = 0; k < 3; k++)
        begin
            rnd_ops();
            run(4'hF);
            chk_units(9);
        end
        bus(1'b1, CFG_ADDR, 32'h0000_0044);
        bus(1'b0, CFG_ADDR, 32'h0);
        `CHK(q, 32'h0000_0044)
        for (int k = 0; k < 3; k++)
        begin
            rnd_ops();
            run(4'hF);
            chk_units(18);
        end
        // Extreme corners force both clamp directions on the low pair
        rnd_ops();
        @(posedge hclk);
        {opnd_set.a[0], opnd_set.b[0], opnd_set.a[1]} <= {3{18'h20000}};
        opnd_set.b[1] <= 18'h1FFFF;
        {ctrl_set.sign_a, ctrl_set.sign_b} <= 2'b11;
        ctrl_set.product_pair_lo_saturate <= 1'b1;
        {ctrl_set.product_pair_hi_round, ctrl_set.product_pair_hi_saturate} <= 2'b11;
        run(4'hF);
        chk_units(18);
        hs = 1'b0;
        for (int i = 2; i < 4; i++)
            hs = hs | (rs(pr(i), 1'b1, 1'b1) !== rs(pr(i), 1'b1, 1'b0));
        run(4'h0);
        bus(1'b0, STAT_ADDR, 32'h0);
        `CHK(q[3:0], {2'b00, hs, 1'b1})
        bus(1'b1, STAT_ADDR, 32'h0000_0003);
        bus(1'b0, STAT_ADDR, 32'h0);
        `CHK(q[3:0], 4'h0)
        // Accumulate: load, three adds, two subtracts; result trails the sum by one edge
        bus(1'b1, CFG_ADDR, 32'h0000_0055);
        rnd_ops();
        @(posedge hclk);
        {ctrl_set.sign_a, ctrl_set.sign_b} <= 2'b11;
        {ctrl_set.product_pair_hi_round, ctrl_set.product_pair_hi_saturate} <= 2'b00;
        ctrl_set.product_pair_lo_saturate <= 1'b0;
        ctrl_set.accum_load <= 2'b11;
        run(4'hF);
        @(posedge hclk);
        ctrl_set.accum_load <= 2'b00;
        {ctrl_set.sum_add_or_subtract_hi, ctrl_set.sum_add_or_subtract_lo} <= 2'b11;
        repeat (3) @(posedge hclk);
        {ctrl_set.sum_add_or_subtract_hi, ctrl_set.sum_add_or_subtract_lo} <= 2'b00;
        @(posedge hclk);
        run(4'h0);
        for (int h = 0; h < 2; h++)
        begin
            e = 3 * pr(2 * h);
            `CHK(result[72*h+:54], e[53:0])
            `CHK(result[72*h+54+:18], 18'h0)
        end
        // Two-product sums, low half subtracting, high half adding
        bus(1'b1, CFG_ADDR, 32'h0000_0066);
        rnd_ops();
        @(posedge hclk);
        ctrl_set.sum_add_or_subtract_hi <= 1'b1;
        run(4'hF);
        e = pr(0) - pr(1);
        `CHK(result[0+:54], e[53:0])
        e = pr(2) + pr(3);
        `CHK(result[72+:54], e[53:0])
        bus(1'b1, CFG_ADDR, 32'h0000_0007);
        run(4'hF);
        e = pr(0) - pr(1) + pr(2) + pr(3);
        `CHK(result[0+:54], e[53:0])
        // Four-product sums at 9x9: low parts in words 0-1, high parts in words 2-3
        bus(1'b1, CFG_ADDR, 32'h0000_0003);
        run(4'hF);
        for (int j = 0; j < 2; j++)
        begin
            e = '0;
            for (int i = 0; i < 4; i++)
            begin
                p = mul(opnd_set.a[i][9*j+:9], opnd_set.b[i][9*j+:9], 9,
                        ctrl_set.sign_a, ctrl_set.sign_b);
                e = (i == 1) ? e - p : e + p;
            end
            `CHK(result[36*j+:36], e[35:0])
        end
        bus(1'b1, CFG_ADDR, 32'h0000_0008);
        rnd_ops();
        run(4'hF);
        p = mul({opnd_set.a[1], opnd_set.a[0]}, {opnd_set.b[1], opnd_set.b[0]}, 36,
                ctrl_set.sign_a, ctrl_set.sign_b);
        `CHK(result, {72'h0, p[71:0]})
        bus(1'b1, CFG_ADDR, 32'h0000_0081);
        bus(1'b0, STAT_ADDR, 32'h0);
        `CHK(q[3:2], 2'b11)
        // Chain on every A register: the chain value reaches the block's far end
        bus(1'b1, CFG_ADDR, 32'h0000_0F00);
        @(posedge hclk);
        chain_set.a <= 18'($random(seed));
        run(4'hF);
        `CHK(chain_out.a, chain_set.a)
        `CHK(chain_out.b, opnd_set.b[3])
        @(posedge hclk);
        ctrl_set.unit_async_clear <= 4'hF;
        run(4'h0);
        `CHK(result, {RESW{1'b0}})
        `CHK(chain_out, 36'h0)
        final_report();
    end
endmodule

`default_nettype wire
